// *** cbs_bus_ctrl.sv ***
// Purpose: Bus cycle sequencer with status, strobes, chip select and pins
// Assumes: All inputs synchronous to ref_clk; core requests one cycle at a time
// Notes:   Bus pin outputs are registered from the next state
`timescale 1ns/1ns
`include "cbs_regs.svh"

module cbs_bus_ctrl
    import cbs_pkg::*;
#(
    parameter int ADDR_W  = `CBS_ADDR_W,
    parameter int DATA_W  = `CBS_DATA_W,
    parameter int NUM_TMR = `CBS_NUM_TMR
) (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                res_n,
    output logic                     sys_reset,
    input  wire logic                req_valid,
    input  wire cbs_req_t            req,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_rdata,
    input  wire logic                int_en,
    output logic [DATA_W-1:0]        ad_out,
    output logic                     ad_oe,
    input  wire logic [DATA_W-1:0]   ad_in,
    output logic [3:0]               upper_lines,
    output logic                     cycle_status_bit0,
    output logic                     cycle_status_bit1,
    output logic                     cycle_status_bit2,
    output logic                     rd_n,
    output logic                     wr_n,
    output logic                     rfsh_n,
    output logic                     ucs_n,
    input  wire logic [ADDR_W-1:0]   ucs_start,
    input  wire logic                srdy,
    input  wire logic                test_n,
    input  wire logic                wait_exec,
    output logic                     core_hold,
    input  wire cbs_tmr_cfg_t        tmr_cfg [NUM_TMR],
    input  wire logic [NUM_TMR-1:0]  tmr_enable,
    input  wire logic [NUM_TMR-1:0]  tmr_in,
    output logic [NUM_TMR-1:0]       tmr_out
);

    generate
        if (ADDR_W != `CBS_ADDR_W || DATA_W != `CBS_DATA_W || NUM_TMR < 1) begin : g_chk
            $error("cbs_bus_ctrl: bus widths are fixed and at least one timer is needed");
        end
    endgenerate

    cbs_state_t        state_r;
    cbs_state_t        state_nxt;
    cbs_req_t          cur_r;
    cbs_req_t          cur_nxt;
    logic [2:0]        status_r;
    logic [2:0]        status_nxt;
    cbs_upper_t        upper_r;
    cbs_upper_t        upper_nxt;
    logic [DATA_W-1:0] ad_out_r;
    logic [DATA_W-1:0] ad_out_nxt;
    logic              ad_oe_r;
    logic              rd_n_r;
    logic              wr_n_r;
    logic              rfsh_n_r;
    logic              ucs_n_r;
    logic              rsp_valid_r;
    logic [DATA_W-1:0] rsp_rdata_r;
    logic              sys_reset_r;
    logic              core_hold_r;

    // Cycle state sequencing; reset input low forces idle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CBS_S_IDLE: begin
                if (req_valid) begin
                    state_nxt = CBS_S_T1;
                end
            end
            CBS_S_T1: begin
                state_nxt = CBS_S_T2;
            end
            CBS_S_T2: begin
                state_nxt = CBS_S_T3;
            end
            CBS_S_T3: begin
                if (srdy || cur_r.kind == CBS_K_HALT) begin
                    state_nxt = CBS_S_T4;
                end
            end
            CBS_S_T4: begin
                state_nxt = CBS_S_IDLE;
            end
            default: begin
                state_nxt = CBS_S_IDLE;
            end
        endcase
        if (!res_n) begin
            state_nxt = CBS_S_IDLE;
        end
    end

    // Request acceptance and latched cycle
    assign req_ready = (state_r == CBS_S_IDLE) & res_n;
    assign cur_nxt   = (req_valid && req_ready) ? req : cur_r;

    // Decode of the cycle kind
    wire cbs_kind_t k      = cur_nxt.kind;
    wire            is_rd  = (k == CBS_K_IORD) | (k == CBS_K_MRD) | (k == CBS_K_FETCH) | (k == CBS_K_RFSH);
    wire            is_wr  = (k == CBS_K_IOWR) | (k == CBS_K_MWR);
    wire            is_mem = (k == CBS_K_MRD) | (k == CBS_K_MWR) | (k == CBS_K_FETCH) | (k == CBS_K_RFSH);
    wire            nxt_t1 = (state_nxt == CBS_S_T1);
    wire            nxt_ts = (state_nxt == CBS_S_T2) | (state_nxt == CBS_S_T3);
    wire            in_cyc = nxt_t1 | nxt_ts;
    wire            strobe = nxt_ts & (k != CBS_K_HALT);
    wire            in_ucs = (cur_nxt.addr >= ucs_start);

    // Cycle status lines; refresh shows as a memory read
    assign status_nxt = !in_cyc ? `CBS_ST_IDLE :
                        (k == CBS_K_RFSH) ? `CBS_ST_MRD : 3'(k);

    // Upper lines: address in the first state, status afterwards
    assign upper_nxt = nxt_t1 ? cur_nxt.addr[`CBS_UP_HI:`CBS_UP_LO] :
                       {1'b0, int_en, 1'b0, 1'b0};

    // Address/data bus: low address in T1, write data to cycle end
    assign ad_out_nxt = nxt_t1 ? cur_nxt.addr[DATA_W-1:0] : cur_nxt.wdata;
    wire   ad_oe_nxt  = nxt_t1 | (is_wr & (nxt_ts | (state_nxt == CBS_S_T4)));

    // Registered pin outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r  <= CBS_S_IDLE;
            cur_r    <= '0;
            status_r <= `CBS_ST_IDLE;
            upper_r  <= '0;
            ad_out_r <= '0;
            ad_oe_r  <= 1'b0;
            rd_n_r   <= 1'b1;
            wr_n_r   <= 1'b1;
            rfsh_n_r <= 1'b1;
            ucs_n_r  <= 1'b1;
        end else begin
            state_r  <= state_nxt;
            cur_r    <= cur_nxt;
            status_r <= status_nxt;
            upper_r  <= upper_nxt;
            ad_out_r <= ad_out_nxt;
            ad_oe_r  <= ad_oe_nxt;
            rd_n_r   <= ~(strobe & is_rd);
            wr_n_r   <= ~(strobe & is_wr);
            rfsh_n_r <= ~(in_cyc & (k == CBS_K_RFSH));
            ucs_n_r  <= ~(in_cyc & is_mem & in_ucs);
        end
    end

    // Read data capture, system reset and wait-instruction hold
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= '0;
            sys_reset_r <= 1'b1;
            core_hold_r <= 1'b0;
        end else begin
            rsp_valid_r <= res_n & (state_r == CBS_S_T3) & srdy &
                           (is_rd | (cur_r.kind == CBS_K_INTA));
            if (state_r == CBS_S_T3 && srdy) begin
                rsp_rdata_r <= ad_in;
            end
            sys_reset_r <= ~res_n;
            core_hold_r <= wait_exec & test_n;
        end
    end

    assign sys_reset         = sys_reset_r;
    assign core_hold         = core_hold_r;
    assign rsp_valid         = rsp_valid_r;
    assign rsp_rdata         = rsp_rdata_r;
    assign ad_out            = ad_out_r;
    assign ad_oe             = ad_oe_r;
    assign upper_lines       = upper_r;
    assign cycle_status_bit0 = status_r[0];
    assign cycle_status_bit1 = status_r[1];
    assign cycle_status_bit2 = status_r[2];
    assign rd_n              = rd_n_r;
    assign wr_n              = wr_n_r;
    assign rfsh_n            = rfsh_n_r;
    assign ucs_n             = ucs_n_r;

    // Timer channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
            cbs_timer #(.W(`CBS_TMR_W)) u_tmr (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .cfg     (tmr_cfg[gi]),
                .enable  (tmr_enable[gi]),
                .tmr_in  (tmr_in[gi]),
                .tmr_out (tmr_out[gi])
            );
        end
    endgenerate

    // Checks on the pin behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wire [2:0] st_lines = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};

    property p_dormant;
        !res_n |=> state_r == CBS_S_IDLE && st_lines == 3'h7 && (res_n || !req_ready);
    endproperty
    a_dormant: assert property (p_dormant) else $error("activity while reset input low");

    property p_reset_out;
        !res_n ##1 !res_n |-> sys_reset;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset output not active");

    property p_rfsh;
        (state_r == CBS_S_T2) |-> (rfsh_n == (cur_r.kind != CBS_K_RFSH));
    endproperty
    a_rfsh: assert property (p_rfsh) else $error("refresh output wrong in cycle");

    property p_io_codes;
        (state_r == CBS_S_T2) && (cur_r.kind inside {CBS_K_INTA, CBS_K_IORD, CBS_K_IOWR})
            |-> st_lines == 3'(cur_r.kind);
    endproperty
    a_io_codes: assert property (p_io_codes) else $error("wrong I/O or acknowledge status");

    property p_halt_fetch;
        (state_r == CBS_S_T1) && (cur_r.kind inside {CBS_K_HALT, CBS_K_FETCH})
            |-> st_lines == ((cur_r.kind == CBS_K_HALT) ? 3'h3 : 3'h4);
    endproperty
    a_halt_fetch: assert property (p_halt_fetch) else $error("wrong halt or fetch status");

    property p_idle_code;
        (state_r == CBS_S_IDLE || state_r == CBS_S_T4) |-> st_lines == 3'h7;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle bus not showing 111");

    property p_upper;
        (state_r == CBS_S_T1) |-> upper_lines == cur_r.addr[19:16] ##1 upper_lines[1:0] == 2'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper lines wrong");

    property p_wait_hold;
        wait_exec && test_n |=> core_hold;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("no suspend while test high");

    property p_wait_release;
        !test_n |=> !core_hold;
    endproperty
    a_wait_release: assert property (p_wait_release) else $error("no resume on test low");

    property p_ucs;
        (state_r == CBS_S_T2) && (cur_r.kind == CBS_K_MRD) && (cur_r.addr >= ucs_start) && $stable(ucs_start)
            |-> !ucs_n;
    endproperty
    a_ucs: assert property (p_ucs) else $error("upper select missing");

    property p_wr;
        (state_r == CBS_S_T2) && (cur_r.kind == CBS_K_MWR) |-> !wr_n && ad_oe && ad_out == cur_r.wdata;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe without data");

    property p_rd;
        (state_r == CBS_S_T3) && (cur_r.kind == CBS_K_IORD) |-> !rd_n && wr_n && !ad_oe;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe missing");

    property p_srdy;
        (state_r == CBS_S_T3) && !srdy && res_n && (cur_r.kind != CBS_K_HALT) |=> state_r == CBS_S_T3;
    endproperty
    a_srdy: assert property (p_srdy) else $error("cycle ended without ready");

    c_mem_read: cover property (state_r == CBS_S_T3 && srdy && cur_r.kind == CBS_K_MRD);
    c_wait_st:  cover property (state_r == CBS_S_T3 && !srdy ##1 state_r == CBS_S_T3 && srdy);
    c_refresh:  cover property (!rfsh_n ##1 !rfsh_n);
    c_abort:    cover property (state_r == CBS_S_T2 && !res_n);

endmodule : cbs_bus_ctrl

// *** cbs_regs.svh ***
// Purpose: Constants of the bus cycle and status signalling block
// Assumes: Included by the package and by the design modules
// Notes:   Cycle status codes are the active-low line levels {bit2,bit1,bit0}
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// Cycle status line codes
`define CBS_ST_INTA  3'h0
`define CBS_ST_IORD  3'h1
`define CBS_ST_IOWR  3'h2
`define CBS_ST_HALT  3'h3
`define CBS_ST_FETCH 3'h4
`define CBS_ST_MRD   3'h5
`define CBS_ST_MWR   3'h6
`define CBS_ST_IDLE  3'h7

// Bus widths and the multiplexed upper address field
`define CBS_ADDR_W   20
`define CBS_DATA_W   16
`define CBS_UP_HI    19
`define CBS_UP_LO    16
`define CBS_TMR_W    16
`define CBS_NUM_TMR  2

`endif

// *** cbs_pkg.sv ***
// Purpose: Types of the bus cycle and status signalling block
// Assumes: cbs_regs.svh holds the numeric constants
// Notes:   Request kinds reuse the status codes; refresh takes the idle code 7
`include "cbs_regs.svh"

package cbs_pkg;

    // Kinds of bus cycle the core can request
    typedef enum logic [2:0] {
        CBS_K_INTA  = 3'h0,
        CBS_K_IORD  = 3'h1,
        CBS_K_IOWR  = 3'h2,
        CBS_K_HALT  = 3'h3,
        CBS_K_FETCH = 3'h4,
        CBS_K_MRD   = 3'h5,
        CBS_K_MWR   = 3'h6,
        CBS_K_RFSH  = 3'h7
    } cbs_kind_t;

    // Bus cycle states, one-hot
    typedef enum logic [4:0] {
        CBS_S_IDLE = 5'h01,
        CBS_S_T1   = 5'h02,
        CBS_S_T2   = 5'h04,
        CBS_S_T3   = 5'h08,
        CBS_S_T4   = 5'h10
    } cbs_state_t;

    typedef struct packed {
        cbs_kind_t                 kind;
        logic [`CBS_ADDR_W-1:0]    addr;
        logic [`CBS_DATA_W-1:0]    wdata;
    } cbs_req_t;

    typedef struct packed {
        logic upper_status_bit6;
        logic upper_status_bit5;
        logic upper_status_bit4;
        logic upper_status_bit3;
    } cbs_upper_t;

    typedef struct packed {
        logic                      ext_clk;
        logic                      gate_trig;
        logic                      continuous;
        logic [`CBS_TMR_W-1:0]     max_count;
    } cbs_tmr_cfg_t;

endpackage : cbs_pkg

// *** cbs_timer.sv ***
// Purpose: One timer channel with its input and output pin
// Assumes: tmr_in is synchronous to ref_clk
// Notes:   Single mode gives a one-cycle pulse, continuous mode a square wave
`timescale 1ns/1ns
`include "cbs_regs.svh"

module cbs_timer
    import cbs_pkg::*;
#(
    parameter int W = `CBS_TMR_W
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire cbs_tmr_cfg_t cfg,
    input  wire logic         enable,
    input  wire logic         tmr_in,
    output logic              tmr_out
);

    generate
        if (W != `CBS_TMR_W) begin : g_chk
            $error("cbs_timer: W must match the configured count width");
        end
    endgenerate

    logic [W-1:0] cnt_r;
    logic         tin_r;
    logic         out_r;
    logic         done_r;

    // Input pin role: counting clock, gate, or retrigger
    wire rise    = tmr_in & ~tin_r;
    wire restart = ~cfg.ext_clk & cfg.gate_trig & ~cfg.continuous & rise;
    wire gated   = cfg.gate_trig & cfg.continuous & ~tmr_in;
    wire tick    = enable & ~done_r & (cfg.ext_clk ? rise : ~gated);
    wire term    = tick & (cnt_r == cfg.max_count);

    // Counter, terminal action and output waveform
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            tin_r  <= 1'b0;
            out_r  <= 1'b0;
            done_r <= 1'b0;
        end else begin
            tin_r <= tmr_in;
            if (!enable || restart) begin
                cnt_r  <= '0;
                done_r <= 1'b0;
                out_r  <= 1'b0;
            end else if (term) begin
                cnt_r  <= '0;
                done_r <= ~cfg.continuous;
                out_r  <= cfg.continuous ? ~out_r : 1'b1;
            end else begin
                if (tick) begin
                    cnt_r <= cnt_r + 1'b1;
                end
                if (!cfg.continuous) begin
                    out_r <= 1'b0;
                end
            end
        end
    end

    assign tmr_out = out_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_single_pulse;
        out_r && !cfg.continuous && $stable(cfg.continuous) |=> !out_r;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("single pulse wider than one cycle");

    property p_ext_clk;
        cfg.ext_clk && $stable(cfg) && enable && !rise && !restart |=> $stable(cnt_r);
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("external clock mode counted without an edge");

endmodule : cbs_timer

// *** cbs_slave_model.sv ***
// Purpose: Memory and I/O slave on the far side of the bus
// Assumes: Strobes, status and address come from cbs_bus_ctrl
// Notes:   Released data lines flip every cycle so stale data is never seen
`timescale 1ns/1ns

module cbs_slave_model
    import cbs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [3:0]  upper_lines,
    input  wire logic [15:0] ad_out,
    input  wire logic        ad_oe,
    input  wire logic [2:0]  status,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [3:0]  waits,
    output logic      [15:0] ad_in,
    output logic             srdy
);
    logic [15:0] mem [256];
    logic [19:0] addr_r;
    logic [3:0]  cnt_r;

    // Quiet start
    initial begin
        ad_in = 16'h0000;
        srdy = 1'b0;
        cnt_r = 4'h0;
        addr_r = 20'h00000;
    end

    // Address latch, write capture, read drive and ready delay
    always @(posedge ref_clk) begin
        if (ad_oe && rd_n && wr_n && status != 3'h7) begin
            addr_r <= {upper_lines, ad_out};
        end
        if (!wr_n) begin
            mem[addr_r[7:0]] <= ad_out;
        end
        if (!rd_n) begin
            ad_in <= mem[addr_r[7:0]];
        end else begin
            ad_in <= ~ad_in;
        end
        srdy <= (status != 3'h7) && (cnt_r >= waits);
        cnt_r <= (status != 3'h7) ? cnt_r + 4'h1 : 4'h0;
    end
endmodule : cbs_slave_model

// *** cbs_bus_ctrl_tb.sv ***
// Purpose: Self-checking bench of the bus cycle and status block
// Assumes: Inputs change at the falling edge; slave model answers strobes
// Notes:   Expected values come from the status code table and the hand-over timing
`timescale 1ns/1ns

module cbs_bus_ctrl_tb import cbs_pkg::*;;
    localparam logic [7:0] RDM = 8'hb2;
    localparam logic [7:0] WRM = 8'h44;
    logic         ref_clk, rst_n, res_n, sys_reset, req_valid, req_ready, rsp_valid;
    logic         int_en, ad_oe, rd_n, wr_n, rfsh_n, ucs_n, srdy, test_n, wait_exec, core_hold;
    logic         cycle_status_bit0, cycle_status_bit1, cycle_status_bit2;
    logic         rf1, ucs1, rd2, wr2, rv;
    cbs_req_t     req;
    logic [15:0]  rsp_rdata, ad_out, ad_in, rdata;
    logic [19:0]  ucs_start;
    logic [3:0]   upper_lines, waits, up1, up2;
    logic [2:0]   st1, st_end, status;
    logic [1:0]   tmr_enable, tmr_in, tmr_out;
    cbs_tmr_cfg_t tmr_cfg [2];
    int           n_errors = 0;
    int           tests_run = 0;
    int           lat, tog, hi1;

    assign status = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};

    cbs_bus_ctrl u_cbs_bus_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .res_n(res_n), .sys_reset(sys_reset),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .int_en(int_en), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in),
        .upper_lines(upper_lines), .cycle_status_bit0(cycle_status_bit0),
        .cycle_status_bit1(cycle_status_bit1), .cycle_status_bit2(cycle_status_bit2),
        .rd_n(rd_n), .wr_n(wr_n), .rfsh_n(rfsh_n), .ucs_n(ucs_n), .ucs_start(ucs_start),
        .srdy(srdy), .test_n(test_n), .wait_exec(wait_exec), .core_hold(core_hold),
        .tmr_cfg(tmr_cfg), .tmr_enable(tmr_enable), .tmr_in(tmr_in), .tmr_out(tmr_out)
    );

    cbs_slave_model u_cbs_slave_model (
        .ref_clk(ref_clk), .upper_lines(upper_lines), .ad_out(ad_out), .ad_oe(ad_oe),
        .status(status), .rd_n(rd_n), .wr_n(wr_n), .waits(waits), .ad_in(ad_in), .srdy(srdy)
    );

    // Compare and count
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    // One bus cycle from the core side; records pin levels in T1 and T2
    task automatic run_cycle(input cbs_kind_t k, input logic [19:0] a, input logic [15:0] d);
        int i;
        req = {k, a, d};
        req_valid = 1'b1;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge ref_clk);
        if (req_ready !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        {st1, rf1, ucs1, up1} = {status, rfsh_n, ucs_n, upper_lines};
        @(negedge ref_clk);
        {rd2, wr2, up2} = {rd_n, wr_n, upper_lines};
        // Cycle ends when the status lines go passive (T4); writes and halts give no answer pulse
        lat = 0;
        for (i = 3; i < 30 && lat == 0; i++) begin
            @(negedge ref_clk);
            if (status === 3'h7) lat = i;
        end
        if (lat == 0) begin
            n_errors++;
            give_verdict();
        end
        {rdata, rv} = {rsp_rdata, rsp_valid};
        @(negedge ref_clk);
        st_end = status;
    endtask : run_cycle

    // Every cycle kind: status code, strobes, upper lines and answer time
    task automatic test_kinds();
        cbs_kind_t k;
        for (int n = 0; n < 8; n++) begin
            k = cbs_kind_t'(n);
            run_cycle(k, 20'ha3c12, 16'h0f0f);
            check("status T1", 20'(st1), (k == CBS_K_RFSH) ? 20'h5 : 20'(n));
            check("refresh", 20'(rf1), 20'(k != CBS_K_RFSH));
            check("read strobe", 20'(rd2), 20'(!RDM[n]));
            check("write strobe", 20'(wr2), 20'(!WRM[n]));
            check("answer pulse", 20'(rv), 20'(RDM[n] || n == 0));
            check("upper T1", 20'(up1), 20'ha);
            check("upper T2", 20'(up2), 20'h4);
            check("select out of range", 20'(ucs1), 20'h1);
            check("latency", 20'(lat), 20'h4);
            check("status end", 20'(st_end), 20'h7);
        end
        $display("test kinds done");
    endtask : test_kinds

    // Write and read back with wait states, select boundary, I/O space
    task automatic test_mem();
        run_cycle(CBS_K_MWR, 20'hf0010, 16'hbeef);
        check("select in range", 20'(ucs1), 20'h0);
        waits = 4'h3;
        run_cycle(CBS_K_MRD, 20'hf0010, 16'h0000);
        check("read back", 20'(rdata), 20'hbeef);
        check("wait latency", 20'(lat), 20'h6);
        waits = 4'h0;
        run_cycle(CBS_K_MRD, 20'hefff0, 16'h0000);
        check("select below start", 20'(ucs1), 20'h1);
        run_cycle(CBS_K_FETCH, 20'hf0000, 16'h0000);
        check("select at start", 20'(ucs1), 20'h0);
        run_cycle(CBS_K_IOWR, 20'h00020, 16'h1234);
        run_cycle(CBS_K_IORD, 20'h00020, 16'h0000);
        check("io read back", 20'(rdata), 20'h1234);
        check("io select", 20'(ucs1), 20'h1);
        $display("test memory done");
    endtask : test_mem

    // Reset pin pulled low in the middle of a read
    task automatic test_res();
        @(negedge ref_clk);
        req = {CBS_K_MRD, 20'hf0010, 16'h0000};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        @(negedge ref_clk);
        res_n = 1'b0;
        @(negedge ref_clk);
        check("abandon status", 20'({status, rd_n, rsp_valid}), 20'h1e);
        check("ready in reset", 20'(req_ready), 20'h0);
        @(negedge ref_clk);
        check("reset out", 20'(sys_reset), 20'h1);
        res_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("reset out off", 20'(sys_reset), 20'h0);
        run_cycle(CBS_K_MRD, 20'hf0010, 16'h0000);
        check("resume read", 20'(rdata), 20'hbeef);
        $display("test reset pin done");
    endtask : test_res

    // Wait instruction held by the test input
    task automatic test_hold();
        wait_exec = 1'b1;
        test_n = 1'b1;
        @(negedge ref_clk);
        check("hold", 20'(core_hold), 20'h1);
        test_n = 1'b0;
        @(negedge ref_clk);
        check("release", 20'(core_hold), 20'h0);
        wait_exec = 1'b0;
        test_n = 1'b1;
        @(negedge ref_clk);
        check("no wait", 20'(core_hold), 20'h0);
        $display("test wait done");
    endtask : test_hold

    // Count timer 0 toggles and timer 1 high cycles
    task automatic watch(input int n, input logic tgl);
        logic prev;
        prev = tmr_out[0];
        tog = 0;
        hi1 = 0;
        repeat (n) begin
            @(negedge ref_clk);
            tmr_in[1] = tmr_in[1] ^ tgl;
            tog += int'(tmr_out[0] !== prev);
            hi1 += int'(tmr_out[1] === 1'b1);
            prev = tmr_out[0];
        end
    endtask : watch

    // Free-running, gated and external-clock single-shot timers
    task automatic test_timers();
        tmr_cfg[0] = {1'b0, 1'b0, 1'b1, 16'h0003};
        tmr_cfg[1] = {1'b1, 1'b0, 1'b0, 16'h0002};
        tmr_enable = 2'b11;
        watch(24, 1'b0);
        check("free toggles", 20'(tog >= 5 && tog <= 6), 20'h1);
        check("no ext ticks", 20'(hi1), 20'h0);
        tmr_cfg[0] = {1'b0, 1'b1, 1'b1, 16'h0003};
        watch(24, 1'b1);
        check("gated toggles", 20'(tog), 20'h0);
        check("single pulse", 20'(hi1), 20'h1);
        // Internal clock, single shot, input edge retriggers: one pulse per input period
        tmr_cfg[1] = {1'b0, 1'b1, 1'b0, 16'h0000};
        watch(24, 1'b1);
        check("retriggered pulses", 20'(hi1), 20'hb);
        $display("test timers done");
    endtask : test_timers

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Main sequence
    initial begin
        {rst_n, res_n, req_valid, req, int_en, ucs_start, waits} = {3'b010, 39'h0, 1'b1, 20'hf0000, 4'h0};
        {test_n, wait_exec, tmr_enable, tmr_in} = 6'h20;
        tmr_cfg[0] = '0;
        tmr_cfg[1] = '0;
        repeat (6) @(negedge ref_clk);
        check("reset out in reset", 20'(sys_reset), 20'h1);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("idle status", 20'(status), 20'h7);
        check("idle strobes", 20'({rd_n, wr_n, rfsh_n, ucs_n}), 20'hf);
        check("reset out idle", 20'(sys_reset), 20'h0);
        test_kinds();
        test_mem();
        test_res();
        test_hold();
        test_timers();
        give_verdict();
    end
endmodule : cbs_bus_ctrl_tb
